// File: bench/kms_keypad.sv
/*
 switch matrix model: a closed key joins one column line to one row line.
 assumes the rows are pulled low on the device side when no key conducts.
*/
`timescale 1ns/1ps
module kms_keypad
    import kms_pkg::*;
(
    input wire logic [kms_pkg::NUM_COLS-1:0] column_outputs,
    input wire logic [kms_pkg::NUM_ROWS*kms_pkg::NUM_COLS-1:0] pressed,
    output logic [kms_pkg::NUM_ROWS-1:0] row_inputs
);
    // all four rows are wired, so no spare port pin is left floating
    always_comb begin
        row_inputs = '0;
        for (int r = 0; r < NUM_ROWS; r++) begin
            for (int c = 0; c < NUM_COLS; c++) begin
                // released keys leave the row at the pull-down level
                row_inputs[r] = row_inputs[r] | (pressed[r*NUM_COLS+c] & column_outputs[c]);
            end
        end
    end
endmodule

// File: bench/tb.sv
/*
 self-checking bench for the key matrix scanner over apb, with a keypad model.
 assumes a shortened clock figure so a scan cycle lasts a few dozen cycles.
*/
`timescale 1ns/1ps
module tb;
    import kms_pkg::*;
    localparam int TB_CLK_HZ = 6400;
    // typical speed at quarter duty: 32 Hz frame, clear of flicker
    localparam int TB_DUTY = 4;
    localparam int SCAN_DIV = TB_CLK_HZ / (32 * TB_DUTY * 2);
    typedef struct {logic [7:0] setup; logic [15:0] mask;} kms_case_t;
    kms_case_t cases [8] = '{'{8'h00, 16'h0001}, '{8'h0F, 16'h8000}, '{8'h1F, 16'hFFFF},
        '{8'h83, 16'h00FF}, '{8'h98, 16'hFF00}, '{8'hA4, 16'h00F0}, '{8'hBE, 16'hC000},
        '{8'hB2, 16'h000C}};
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, halt_release, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] seg, column_outputs;
    logic [3:0] row_inputs;
    logic [63:0] pressed;
    int failures = 0;
    int checked = 0;

    always #2.5 pclk = ~pclk;

    kms_scanner #(.CLK_HZ(TB_CLK_HZ), .DUTY(TB_DUTY), .SPEED(1)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .row_inputs(row_inputs), .shared_segment_outputs(seg),
        .column_outputs(column_outputs), .halt_release(halt_release), .irq(irq));

    kms_keypad key_u (.column_outputs(column_outputs), .pressed(pressed),
        .row_inputs(row_inputs));

    task automatic finish_test;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // bounded wait: a missing interrupt ends the run as a mismatch
    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 200) begin
            failures++;
            finish_test();
        end
    endtask

    initial begin
        logic [31:0] r;
        logic e;
        longint t0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        seg = 16'hA5C3;
        pressed = '0;
        repeat (8) @(posedge pclk);
        check({16'h0000, column_outputs}, 32'h0);
        presetn <= 1'b1;
        cyc(3);
        check({16'h0000, column_outputs}, 32'hA5C3);
        rd_chk(A_SETUP_IMM, 32'h20);
        rd_chk(A_STATUS, 32'h0);
        seg <= 16'h3C5A;
        cyc(3);
        check({16'h0000, column_outputs}, 32'h3C5A);
        for (int i = 0; i < 8; i++) begin
            wr(A_SETUP_IMM, {24'h0, cases[i].setup});
            cyc(4);
            check({16'h0, column_outputs}, {16'h0, cases[i].mask});
        end
        wr(A_SETUP_SPLIT, 32'hB5);
        cyc(4);
        check({16'h0000, column_outputs}, 32'h0030);
        wr(A_TBL_DATA, 32'h386);
        wr(A_SETUP_TBL, 32'h3);
        cyc(4);
        check({16'h0000, column_outputs}, 32'h00FF);
        // key wake-up with the press-only trigger
        wr(A_CTRL, 32'h1);
        wr(A_INT_ENABLE, 32'h1);
        wr(A_SETUP_IMM, 32'h10);
        cyc(3 * SCAN_DIV);
        rd_chk(A_STATUS, 32'h0);
        pressed[2*16+5] <= 1'b1;
        wait_irq();
        check({31'h0, halt_release}, 32'h1);
        cyc(2 * SCAN_DIV);
        rd_chk(A_STATUS, 32'h47);
        rd_chk(A_PORT, 32'h4);
        pressed <= '0;
        cyc(2 * SCAN_DIV);
        rd_chk(A_STATUS, 32'h07);
        wr(A_CMD, 32'h21);
        rd_chk(A_STATUS, 32'h07);
        wr(A_CMD, 32'h20);
        rd_chk(A_STATUS, 32'h06);
        wr(A_FLAG_CLR, 32'h6);
        rd_chk(A_STATUS, 32'h0);
        check({31'h0, halt_release}, 32'h0);
        check({31'h0, irq}, 32'h1);
        wr(A_INT_CLEAR, 32'h1);
        cyc(1);
        check({31'h0, irq}, 32'h0);
        // every-cycle trigger, interrupt masked
        wr(A_INT_ENABLE, 32'h0);
        wr(A_SETUP_IMM, 32'h50);
        cyc(2 * SCAN_DIV);
        check({31'h0, irq}, 32'h0);
        rd_chk(A_STATUS, 32'h07);
        // scan period from two consecutive cycle-end events
        wr(A_INT_ENABLE, 32'h2);
        wr(A_INT_CLEAR, 32'h3);
        cyc(1);
        wait_irq();
        t0 = $time;
        wr(A_INT_CLEAR, 32'h2);
        cyc(1);
        wait_irq();
        check(32'(($time - t0) / 5), SCAN_DIV);
        apb(1'b0, 8'h30, 32'h0, r, e);
        check(r, 32'h0);
        check({31'h0, e}, 32'h1);
        // second reset in mid-run
        presetn <= 1'b0;
        cyc(2);
        check({14'h0, column_outputs, irq, halt_release}, 32'h0);
        presetn <= 1'b1;
        cyc(2);
        rd_chk(A_SETUP_IMM, 32'h20);
        rd_chk(A_STATUS, 32'h0);
        finish_test();
    end
endmodule

// File: rtl/kms_pkg.sv
/*
 key matrix scanner package: register map, setup word fields, scan modes, frame table.
 assumes a 200 MHz apb clock and the lcd mask options given as top parameters.
*/
package kms_pkg;
    localparam int NUM_ROWS = 4;
    localparam int NUM_COLS = 16;
    localparam int TBL_DEPTH = 16;
    localparam int TBL_AW = 4;
    localparam int CLK_HZ_DEF = 200_000_000;

    localparam logic [7:0] A_SETUP_IMM = 8'h00;
    localparam logic [7:0] A_SETUP_SPLIT = 8'h04;
    localparam logic [7:0] A_SETUP_TBL = 8'h08;
    localparam logic [7:0] A_TBL_DATA = 8'h0C;
    localparam logic [7:0] A_CTRL = 8'h10;
    localparam logic [7:0] A_CMD = 8'h14;
    localparam logic [7:0] A_STATUS = 8'h18;
    localparam logic [7:0] A_FLAG_CLR = 8'h1C;
    localparam logic [7:0] A_INT_STATUS = 8'h20;
    localparam logic [7:0] A_INT_CLEAR = 8'h24;
    localparam logic [7:0] A_INT_ENABLE = 8'h28;
    localparam logic [7:0] A_PORT = 8'h2C;

    localparam logic [7:0] CMD_CLEAR_REQ = 8'h20;
    localparam logic [7:0] SETUP_RESET = 8'h20;
    localparam int B_TRIG = 6;
    localparam int B_START_CONDITION_FLAG_SEVEN = 1;
    localparam int B_START_CONDITION_FLAG_EIGHT = 2;
    localparam int B_TBL_IDX = 8;
    localparam int INT_BITS = 2;
    localparam int I_REQ = 0;
    localparam int I_CYCLE = 1;

    typedef enum logic [2:0] {
        KMS_ONE = 3'b000,
        KMS_ALL = 3'b001,
        KMS_OFF = 3'b010,
        KMS_RSV = 3'b011,
        KMS_EIGHT_A = 3'b100,
        KMS_EIGHT_B = 3'b101,
        KMS_FOUR = 3'b110,
        KMS_TWO = 3'b111
    } kms_mode_t;

    typedef enum logic [1:0] {
        KMS_SLOW = 2'b00,
        KMS_TYPICAL = 2'b01,
        KMS_FAST = 2'b10
    } kms_speed_t;

    // frame rate in Hz for a duty denominator; duty 0 is output-only
    function automatic int kms_frame_hz(input int duty, input int speed);
        int s;
        int t;
        int f;
        case (duty)
            2, 4: begin s = 16; t = 32; f = 64; end
            3, 6: begin s = 21; t = 42; f = 85; end
            5: begin s = 25; t = 51; f = 102; end
            7: begin s = 18; t = 36; f = 73; end
            8: begin s = 32; t = 64; f = 128; end
            9: begin s = 28; t = 56; f = 113; end
            default: begin s = 0; t = 0; f = 0; end
        endcase
        return (speed == 0) ? s : ((speed == 1) ? t : f);
    endfunction
endpackage

// File: rtl/kms_scanner.sv
/*
 key matrix scanner with apb register slave and one level interrupt.
 assumes row pins are asynchronous and pulled low when released, and that the
 lcd segment values for the shared pins come from the display logic on pclk.
*/
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module kms_scanner
    import kms_pkg::*;
#(
    parameter int CLK_HZ = kms_pkg::CLK_HZ_DEF,
    parameter int DUTY = 4,
    parameter int SPEED = 1
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [kms_pkg::NUM_ROWS-1:0] row_inputs,
    input wire logic [kms_pkg::NUM_COLS-1:0] shared_segment_outputs,
    output logic [kms_pkg::NUM_COLS-1:0] column_outputs,
    output logic halt_release,
    output logic irq
);
    import kms_pkg::*;

    // scan rate follows the lcd alternating clock
    localparam int FRAME_HZ = kms_frame_hz(DUTY, SPEED);
    localparam int SCAN_HZ = FRAME_HZ * DUTY * 2;
    localparam int SCAN_DIV = (SCAN_HZ == 0) ? 1 : CLK_HZ / SCAN_HZ;
    localparam logic [31:0] SCAN_LAST = 32'(SCAN_DIV - 1);
    localparam logic SCAN_PRESENT = (SCAN_HZ != 0);

    typedef enum logic [0:0] {
        KMS_IDLE = 1'b0,
        KMS_DRIVE = 1'b1
    } kms_state_t;

    logic [7:0] setup;
    logic hre_en;
    logic scan_req;
    logic start_condition_flag_seven;
    logic start_condition_flag_eight;
    logic [NUM_ROWS-1:0] port_latch;
    logic [INT_BITS-1:0] int_status;
    logic [INT_BITS-1:0] int_enable;
    logic [31:0] div_cnt;
    logic scan_tick;
    kms_state_t state;
    kms_mode_t mode;
    logic active;
    logic [NUM_COLS-1:0] col_mask;
    logic [NUM_ROWS-1:0] row_meta;
    logic [NUM_ROWS-1:0] row_sync;
    logic [NUM_ROWS-1:0] row_prev;
    logic row_rise;
    logic req_set;
    logic req_clr;
    logic wr_acc;
    logic rd_setup;
    logic mapped;
    logic tbl_pend;
    logic [7:0] tbl_rdata;
    logic [INT_BITS-1:0] int_evt;

    assign wr_acc = psel & penable & pwrite;
    assign pready = 1'b1;
    assign rd_setup = psel & ~penable;

    always_comb begin
        if (paddr == A_SETUP_IMM || paddr == A_SETUP_SPLIT || paddr == A_SETUP_TBL) begin
            mapped = 1'b1;
        end else if (paddr == A_TBL_DATA || paddr == A_CTRL || paddr == A_CMD) begin
            mapped = 1'b1;
        end else if (paddr == A_STATUS || paddr == A_FLAG_CLR || paddr == A_INT_STATUS) begin
            mapped = 1'b1;
        end else if (paddr == A_INT_CLEAR || paddr == A_INT_ENABLE || paddr == A_PORT) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    assign pslverr = psel & penable & ~mapped;

    // read data are captured in the setup phase so the access phase answers at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (rd_setup && !pwrite) begin
            if (paddr == A_SETUP_IMM) begin
                prdata <= {24'h0, setup};
            end else if (paddr == A_CTRL) begin
                prdata <= {31'h0, hre_en};
            end else if (paddr == A_STATUS) begin
                prdata <= {24'h0, port_latch, 1'b0, start_condition_flag_eight, start_condition_flag_seven, scan_req};
            end else if (paddr == A_INT_STATUS) begin
                prdata <= {30'h0, int_status};
            end else if (paddr == A_INT_ENABLE) begin
                prdata <= {30'h0, int_enable};
            end else if (paddr == A_PORT) begin
                prdata <= {28'h0, port_latch};
            end else begin
                prdata <= 32'h0;
            end
        end
    end

    kms_table_mem u_tbl (
        .pclk(pclk),
        .wr_en(wr_acc && paddr == A_TBL_DATA),
        .wr_addr(pwdata[B_TBL_IDX +: TBL_AW]),
        .wr_data(pwdata[7:0]),
        .rd_addr(pwdata[TBL_AW-1:0]),
        .rd_data(tbl_rdata)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tbl_pend <= 1'b0;
        end else begin
            tbl_pend <= wr_acc && paddr == A_SETUP_TBL;
        end
    end

    // the three ways of loading the setup word; table read lands one edge later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup <= SETUP_RESET;
        end else if (tbl_pend) begin
            setup <= tbl_rdata;
        end else if (wr_acc && paddr == A_SETUP_IMM) begin
            setup <= pwdata[7:0];
        end else if (wr_acc && paddr == A_SETUP_SPLIT) begin
            setup <= {pwdata[7:4], pwdata[3:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hre_en <= 1'b0;
            int_enable <= '0;
        end else if (wr_acc && paddr == A_CTRL) begin
            hre_en <= pwdata[0];
        end else if (wr_acc && paddr == A_INT_ENABLE) begin
            int_enable <= pwdata[INT_BITS-1:0];
        end
    end

    assign mode = kms_mode_t'({setup[7], setup[5], setup[4]});
    assign active = SCAN_PRESENT && mode != KMS_OFF && mode != KMS_RSV;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 32'h0;
        end else if (!active || div_cnt == SCAN_LAST) begin
            div_cnt <= 32'h0;
        end else begin
            div_cnt <= div_cnt + 32'h1;
        end
    end

    assign scan_tick = active && div_cnt == SCAN_LAST;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= KMS_IDLE;
        end else begin
            case (state)
                KMS_IDLE: begin
                    if (active) begin
                        state <= KMS_DRIVE;
                    end
                end
                KMS_DRIVE: begin
                    if (!active) begin
                        state <= KMS_IDLE;
                    end
                end
                default: begin
                    state <= KMS_IDLE;
                end
            endcase
        end
    end

    // per column select decode for every scan pattern
    genvar gi;
    generate
        for (gi = 0; gi < NUM_COLS; gi++) begin : g_col
            localparam logic [3:0] IDX = 4'(gi);
            always_comb begin
                case (mode)
                    KMS_ONE: col_mask[gi] = setup[3:0] == IDX;
                    KMS_ALL: col_mask[gi] = 1'b1;
                    KMS_EIGHT_A, KMS_EIGHT_B: col_mask[gi] = setup[3] == IDX[3];
                    KMS_FOUR: col_mask[gi] = setup[3:2] == IDX[3:2];
                    KMS_TWO: col_mask[gi] = setup[3:1] == IDX[3:1];
                    default: col_mask[gi] = 1'b0;
                endcase
            end
        end
    endgenerate

    // the shared pins carry lcd segments whenever the scanner is idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            column_outputs <= '0;
        end else if (state == KMS_DRIVE && active) begin
            column_outputs <= col_mask;
        end else begin
            column_outputs <= shared_segment_outputs;
        end
    end

    // rows are asynchronous pins; unused port pins are assumed set as outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_meta <= '0;
            row_sync <= '0;
            row_prev <= '0;
        end else begin
            row_meta <= row_inputs;
            row_sync <= row_meta;
            row_prev <= row_sync;
        end
    end

    assign row_rise = active && |(row_sync & ~row_prev);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_latch <= '0;
        end else if (scan_tick) begin
            port_latch <= row_sync;
        end
    end

    // key press raises the request only while scanning is active; bit 6 adds every cycle end
    assign req_set = row_rise || (scan_tick && setup[B_TRIG]);
    assign req_clr = wr_acc && paddr == A_CMD && pwdata[7:0] == CMD_CLEAR_REQ;

    // set wins over a clear in the same cycle so no key press is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_req <= 1'b0;
        end else if (req_set) begin
            scan_req <= 1'b1;
        end else if (req_clr) begin
            scan_req <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_condition_flag_seven <= 1'b0;
            start_condition_flag_eight <= 1'b0;
        end else begin
            if (req_set && hre_en) begin
                start_condition_flag_seven <= 1'b1;
            end else if (wr_acc && paddr == A_FLAG_CLR && pwdata[B_START_CONDITION_FLAG_SEVEN]) begin
                start_condition_flag_seven <= 1'b0;
            end
            if (req_set && hre_en) begin
                start_condition_flag_eight <= 1'b1;
            end else if (wr_acc && paddr == A_FLAG_CLR && pwdata[B_START_CONDITION_FLAG_EIGHT]) begin
                start_condition_flag_eight <= 1'b0;
            end
        end
    end

    assign halt_release = start_condition_flag_seven;

    assign int_evt = {scan_tick, req_set};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= '0;
        end else if (wr_acc && paddr == A_INT_CLEAR) begin
            int_status <= (int_status & ~pwdata[INT_BITS-1:0]) | int_evt;
        end else begin
            int_status <= int_status | int_evt;
        end
    end

    assign irq = |(int_status & int_enable);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_imm_write;
        wr_acc && paddr == A_SETUP_IMM && !tbl_pend;
    endsequence

    property p_imm_load;
        s_imm_write |=> setup == $past(pwdata[7:0]);
    endproperty
    a_imm_load: assert property (p_imm_load) else $error("immediate setup not loaded");

    property p_tbl_load;
        wr_acc && paddr == A_SETUP_TBL |=> tbl_pend ##1 setup == $past(tbl_rdata);
    endproperty
    a_tbl_load: assert property (p_tbl_load) else $error("table setup not loaded");

    property p_off_pass;
        mode == KMS_OFF |=> column_outputs == $past(shared_segment_outputs);
    endproperty
    a_off_pass: assert property (p_off_pass) else $error("disabled mode still scans");

    property p_one_col;
        state == KMS_DRIVE && active && mode == KMS_ONE
            |=> column_outputs == $past(16'h0001 << setup[3:0]);
    endproperty
    a_one_col: assert property (p_one_col) else $error("single column wrong");

    property p_all_col;
        state == KMS_DRIVE && active && mode == KMS_ALL |=> column_outputs == 16'hFFFF;
    endproperty
    a_all_col: assert property (p_all_col) else $error("all columns not driven");

    property p_eight_col;
        state == KMS_DRIVE && active && setup[7] && !setup[5]
            |=> column_outputs == ($past(setup[3]) ? 16'hFF00 : 16'h00FF);
    endproperty
    a_eight_col: assert property (p_eight_col) else $error("eight column group wrong");

    property p_req_hold;
        scan_req && !req_clr |=> scan_req;
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped by itself");

    property p_req_clear;
        req_clr && !req_set |=> !scan_req;
    endproperty
    a_req_clear: assert property (p_req_clear) else $error("clear command ignored");

    property p_cycle_req;
        scan_tick && setup[B_TRIG] && hre_en |=> scan_req && start_condition_flag_eight && halt_release;
    endproperty
    a_cycle_req: assert property (p_cycle_req) else $error("cycle end did not request");

    property p_latch;
        scan_tick |=> port_latch == $past(row_sync);
    endproperty
    a_latch: assert property (p_latch) else $error("rows not latched at cycle end");

    property p_four_col;
        state == KMS_DRIVE && active && mode == KMS_FOUR
            |=> column_outputs == $past(16'h000F << {setup[3:2], 2'b00});
    endproperty
    a_four_col: assert property (p_four_col) else $error("four column group wrong");

    // a key press with the wake enable set must both request and release halt
    property p_key_req;
        row_rise && hre_en |=> scan_req && halt_release;
    endproperty
    a_key_req: assert property (p_key_req) else $error("key press not seen");
endmodule

// File: rtl/kms_table_mem.sv
/*
 small table memory holding setup bytes that the scanner can load by index.
 assumes one clock; read data appear one edge after the address.
*/
`timescale 1ns/1ps
module kms_table_mem
    import kms_pkg::*;
(
    input wire logic pclk,
    input wire logic wr_en,
    input wire logic [kms_pkg::TBL_AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [kms_pkg::TBL_AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [TBL_DEPTH];

    // no reset: contents are loaded by software before use
    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
